// File: common/dcc_pkg.sv
// ==================================================
// dual comparator control constants and types
// ==================================================
package dcc_pkg;
   // register indices on the plain port
   localparam logic [2:0] ADDR_CTRL = 3'h0;
   localparam logic [2:0] ADDR_FLAGS2 = 3'h1;
   localparam logic [2:0] ADDR_ENABLES2 = 3'h2;
   localparam logic [2:0] ADDR_INTCTL = 3'h3;
   localparam logic [2:0] ADDR_PORTRD = 3'h4;
   // comparator_control fields
   localparam int BIT_SECOND_RESULT = 7;
   localparam int BIT_FIRST_RESULT = 6;
   localparam int BIT_SECOND_INV = 5;
   localparam int BIT_FIRST_INV = 4;
   localparam int BIT_INPUT_SWITCH = 3;
   localparam int MODE_LSB = 0;
   localparam int MODE_MSB = 2;
   // flag, enable and global bits
   localparam int BIT_CHANGE_FLAG = 6;
   localparam int BIT_CHANGE_EN = 6;
   localparam int BIT_PERIPH_EN = 6;
   localparam int BIT_GLOBAL_EN = 7;
   // reset values
   localparam logic [2:0] MODE_RESET = 3'h7;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   // port pin count: index 0 is pin 1 .. index 5 is pin 6
   localparam int NUM_PINS = 6;
   // analog inputs: pins 3..6 in ana_in index 0..3
   localparam int NUM_ANA = 4;
   // routing modes
   typedef enum logic [2:0] {
      MODE_OFF_ZERO = 3'b000,
      MODE_INDEP = 3'b001,
      MODE_INDEP_OUT = 3'b010,
      MODE_COMMON = 3'b011,
      MODE_COMMON_OUT = 3'b100,
      MODE_SINGLE = 3'b101,
      MODE_MUX_REF = 3'b110,
      MODE_OFF = 3'b111
   } dcc_mode_t;
   // analog source select for a comparator input
   typedef enum logic [2:0] {
      SRC_PIN3 = 3'b000,
      SRC_PIN4 = 3'b001,
      SRC_PIN5 = 3'b010,
      SRC_PIN6 = 3'b011,
      SRC_IREF = 3'b100
   } dcc_src_t;
   // routing of one comparator
   typedef struct packed {
      logic on;
      dcc_src_t pos;
      dcc_src_t neg;
   } dcc_route_t;
   // software-writable control fields
   typedef struct packed {
      logic second_invert;
      logic first_invert;
      logic input_switch;
      dcc_mode_t routing_mode;
   } dcc_ctrl_t;
endpackage

// File: dv/dcc_ana_model.sv
`timescale 1ns/100ps
// ==========================
// analog pins and reference
module dcc_ana_model (
   // clock
   input wire logic ref_clk,
   // levels asked for
   input wire logic [3:0][7:0] lv,
   input wire logic [7:0] ir,
   // analog side
   output logic [3:0][7:0] ana_in,
   output logic [7:0] internal_reference
);
   // levels move just after an edge
   always_ff @(posedge ref_clk) begin
      ana_in <= lv;
      internal_reference <= ir;
   end
endmodule // dcc_ana_model

// File: dv/dcc_checker.sv
`timescale 1ns/100ps
// ==========================
// port checker
module dcc_checker (
   // clock, reset, register port
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // pins
   input wire logic [1:0] port_f_latch,
   input wire logic [1:0] port_f_direction,
   input wire logic [3:0] port_analog_config,
   input wire logic [1:0] pin_out,
   input wire logic [1:0] pin_oe_n,
   input wire logic [3:0] pin_analog,
   // sleep and interrupt
   input wire logic sleep_mode,
   input wire logic irq_request,
   input wire logic wake_request
);
   logic [5:0] ctl;
   logic [2:0] en;
   // shadow of control and enables
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctl <= 6'h07;
         en <= 3'h0;
      end else if (reg_wr) begin
         if (reg_addr == dcc_pkg::ADDR_CTRL) ctl <= reg_wdata[5:0];
         if (reg_addr == dcc_pkg::ADDR_ENABLES2) en[0] <= reg_wdata[6];
         if (reg_addr == dcc_pkg::ADDR_INTCTL) en[2:1] <= reg_wdata[7:6];
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence ctl_rd_s;
      reg_rd && reg_addr == dcc_pkg::ADDR_CTRL;
   endsequence
   rst_state_a: assert property (disable iff (1'b0) rst |=>
      pin_oe_n == 2'h3 && pin_analog == 4'hf && !irq_request)
      else $error("reset state wrong");
   rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   ctl_read_a: assert property (ctl_rd_s |=>
      reg_rdata[5:0] == $past(ctl)) else $error("control fields read wrong");
   oe_gate_a: assert property (!$past(rst) |->
      pin_oe_n == $past(port_f_direction)) else $error("driver enable wrong");
   pin_port_a: assert property (!$past(rst) &&
      $past(ctl[2:0]) != 3'h2 && $past(ctl[2:0]) != 3'h4 |->
      pin_out == $past(port_f_latch)) else $error("pin not port data");
   analog_cfg_a: assert property (!$past(rst) |-> pin_analog ==
      {$past(port_analog_config) < 4'h5, $past(port_analog_config) < 4'h6,
      $past(port_analog_config) < 4'h7, $past(port_analog_config) < 4'h8})
      else $error("analog mode wrong");
   irq_en_a: assert property (irq_request && !reg_wr && !$past(reg_wr) |->
      &en) else $error("request without enables");
   wake_en_a: assert property (wake_request |-> $past(sleep_mode))
      else $error("wake outside sleep");
endmodule // dcc_checker
bind dcc_top dcc_checker chk (.ref_clk(ref_clk), .rst(rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_f_latch(port_f_latch),
   .port_f_direction(port_f_direction), .pin_out(pin_out),
   .port_analog_config(port_analog_config), .pin_oe_n(pin_oe_n),
   .pin_analog(pin_analog), .sleep_mode(sleep_mode),
   .irq_request(irq_request), .wake_request(wake_request));

// File: dv/dual_comparator_control_bench.sv
`timescale 1ns/100ps
// ==========================
// bench
module dual_comparator_control_bench;
   localparam logic [2:0] AC = dcc_pkg::ADDR_CTRL;
   localparam logic [2:0] AF = dcc_pkg::ADDR_FLAGS2;
   logic ref_clk, rst, wr, rd, slp, irq, wk;
   logic [2:0] a;
   logic [7:0] wd, rdat, ir, d, iref;
   logic [3:0][7:0] lv, ana;
   logic [5:0] pd;
   logic [1:0] lat, dir, po, oe, v;
   logic [3:0] cfg, pa;
   int error_cnt, compares, cyc;
   // clock
   initial begin
      ref_clk = 0;
      forever #20 ref_clk = ~ref_clk;
   end
   dcc_ana_model pm (.ref_clk(ref_clk), .lv(lv), .ir(ir), .ana_in(ana),
      .internal_reference(iref));
   dcc_top dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(a), .reg_wdata(wd),
      .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .ana_in(ana),
      .internal_reference(iref), .pin_digital(pd), .port_f_latch(lat),
      .port_f_direction(dir), .port_analog_config(cfg), .pin_out(po),
      .pin_oe_n(oe), .pin_analog(pa), .sleep_mode(slp), .irq_request(irq),
      .wake_request(wk));
   // expected {second, first}
   function automatic logic [1:0] er(input logic [2:0] m, input logic s,
      input logic [1:0] inv);
      logic [7:0] p1, n1, p2, n2;
      p1 = 0; n1 = 0; p2 = lv[0]; n2 = lv[1];
      case (m)
         3'h1, 3'h2: begin p1 = lv[2]; n1 = lv[3]; end
         3'h3, 3'h4: begin p1 = lv[0]; n1 = lv[3]; end
         3'h6: begin
            p1 = ir; n1 = s ? lv[2] : lv[3]; p2 = ir; n2 = s ? lv[0] : lv[1];
         end
         3'h5: ;
         default: p2 = 0;
      endcase
      return {p2 > n2, p1 > n1} ^ inv;
   endfunction
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         $display("FAIL %s exp %h got %h", n, e, g);
         error_cnt++;
      end
   endtask
   task w(input logic [2:0] ad, input logic [7:0] x);
      @(posedge ref_clk); wr <= 1; a <= ad; wd <= x;
      @(posedge ref_clk); wr <= 0;
   endtask
   task r(input logic [2:0] ad);
      @(posedge ref_clk); rd <= 1; a <= ad;
      @(posedge ref_clk); rd <= 0;
      #1 d = rdat;
   endtask
   task print_verdict;
      $display("counts: %0d compares, %0d errors", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // hang guard
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         print_verdict;
      end
   end
   // main sequence
   initial begin
      {wr, rd, a, wd, lv, ir, pd, lat, dir, cfg, slp} = '0;
      {error_cnt, compares, cyc} = '0;
      rst = 1;
      d = 8'($urandom(53143));
      repeat (12) @(posedge ref_clk);
      rst <= 0;
      r(AC); chk("ctrl", 8'h07, d);
      r(3'h7); chk("unmapped", 8'h00, d);
      $display("reset test done");
      for (int i = 0; i < 64; i++) begin
         for (int j = 0; j < 4; j++) lv[j] <= 8'($urandom);
         ir <= 8'($urandom);
         w(AC, {2'h3, i[5:0]});
         repeat (3) @(posedge ref_clk);
         r(AC); chk("ctrl", {er(i[2:0], i[3], i[5:4]), i[5:0]}, d);
      end
      $display("mode test done");
      lv <= {4{8'h40}}; ir <= 8'h80;
      w(AC, 8'h06); repeat (3) @(posedge ref_clk);
      r(AC); w(AF, 8'h00); w(3'h2, 8'h40); w(3'h3, 8'hc0);
      r(AF); chk("flag", 8'h00, d & 8'h40);
      ir <= 8'h10; repeat (4) @(posedge ref_clk);
      r(AF); chk("flag", 8'h40, d & 8'h40);
      chk("irq", 8'h01, {7'h0, irq});
      w(AF, 8'h00); r(AF); chk("flag", 8'h40, d & 8'h40);
      r(AC); w(AF, 8'h00); r(AF); chk("flag", 8'h00, d & 8'h40);
      w(AF, 8'h40); r(AF); chk("flag", 8'h40, d & 8'h40);
      w(3'h3, 8'h40); repeat (2) @(posedge ref_clk);
      chk("irq", 8'h00, {7'h0, irq});
      slp <= 1; repeat (2) @(posedge ref_clk);
      chk("wake", 8'h01, {7'h0, wk});
      slp <= 0; r(AC); chk("ctrl", 8'h06, d);
      $display("flag test done");
      for (int i = 0; i < 8; i++) begin
         for (int j = 0; j < 4; j++) lv[j] <= 8'($urandom);
         dir <= 2'($urandom); lat <= 2'($urandom); v = i[2:1];
         w(AC, {2'h0, v, 1'b0, i[0] ? 3'h2 : 3'h4});
         repeat (3) @(posedge ref_clk);
         chk("pins", {6'h0, er(i[0] ? 3'h2 : 3'h4, 1'b0, v)}, {6'h0, po});
         chk("oe", {6'h0, dir}, {6'h0, oe});
      end
      $display("pin test done");
      for (int c = 0; c < 16; c++) begin
         cfg <= 4'(c); pd <= 6'($urandom);
         r(dcc_pkg::ADDR_PORTRD);
         chk("port", {2'h0, pd[5] & (c > 4), pd[4] & (c > 5),
            pd[3] & (c > 6), pd[2] & (c > 7), pd[1:0]}, d);
      end
      $display("port test done");
      print_verdict;
   end
endmodule // dual_comparator_control_bench

// File: logic/dcc_top.sv
// Function
// (RL1) raw result high when positive exceeds negative
// (RL2) results readable at bits 7,6, write-ignored
// (RL3) invert bits 5,4 flip status and pins
// (RL4) three-bit mode selects eight routings
// (RL5) mode 111 off; reset gives 0x07
// (RL6) mode 110 switch bit picks negatives
// (RL7) internal reference drives positives, mode 110 only
// (RL8) pins carry comparator results when enabled
// (RL9) direction bits still gate pin drivers
// (RL10) flag set on result versus latched mismatch
// (RL11) flag at bit 6; write clears/sets
// (RL12) request needs three enables; flag regardless
// (RL13) control access latches current results
// (RL14) mismatch keeps re-setting the flag
// (RL15) change during control read may be missed
// (RL16) sleep keeps comparing, enabled flag wakes
// (RL17) software masks interrupt while changing mode
// (RL18) analog-configured pins read zero from port
// (RL19) pins analog by config field, analog at reset
// (RL20) other modes follow own routing table
`timescale 1ns/100ps
module dcc_top #(
   parameter int SAMPLE_W = 8,
   parameter logic [3:0] PIN3_DIG_FROM = 4'h8,
   parameter logic [3:0] PIN4_DIG_FROM = 4'h7,
   parameter logic [3:0] PIN5_DIG_FROM = 4'h6,
   parameter logic [3:0] PIN6_DIG_FROM = 4'h5
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // analog side: pin 3..6 samples and internal reference
   input wire logic [dcc_pkg::NUM_ANA-1:0][SAMPLE_W-1:0] ana_in,
   input wire logic [SAMPLE_W-1:0] internal_reference,
   // port f digital context
   input wire logic [dcc_pkg::NUM_PINS-1:0] pin_digital,
   input wire logic [1:0] port_f_latch,
   input wire logic [1:0] port_f_direction,
   input wire logic [3:0] port_analog_config,
   // output pins 1 and 2
   output logic [1:0] pin_out,
   output logic [1:0] pin_oe_n,
   // analog mode of pins 3..6
   output logic [dcc_pkg::NUM_ANA-1:0] pin_analog,
   // interrupt and wake
   input wire logic sleep_mode,
   output logic irq_request,
   output logic wake_request
);
   localparam int NUM_ANA_P = dcc_pkg::NUM_ANA;

   // ==================================================
   // state
   // ==================================================
   typedef struct packed {
      dcc_pkg::dcc_ctrl_t ctrl;
      logic [1:0] result;
      logic [1:0] latched;
      logic flag;
      logic change_en;
      logic periph_en;
      logic global_en;
      logic [7:0] rdata;
      logic [1:0] pout;
      logic [1:0] poe_n;
      logic [NUM_ANA_P-1:0] analog;
      logic irq;
      logic wake;
   } dcc_state_t;

   dcc_state_t st;
   dcc_state_t next_st;

   // ==================================================
   // routing table
   // ==================================================
   // returns routing of comparator idx (0 first, 1 second)
   // 000: both off
   // 001: first pin5/pin6, second pin3/pin4
   // 010: as 001, results also on pins 1 and 2
   // 011: first pin3/pin6, second pin3/pin4
   // 100: as 011, results also on pins 1 and 2
   // 101: first off, second pin3/pin4
   // 110: both on the internal reference, negatives by switch
   // 111: both off
   // an off comparator gives raw low, inversion still applies
   function automatic dcc_pkg::dcc_route_t route_of(
      input dcc_pkg::dcc_mode_t mode,
      input logic sw,
      input logic idx
   );
      dcc_pkg::dcc_route_t r;
      r.on = 1'b1;
      r.pos = idx ? dcc_pkg::SRC_PIN3 : dcc_pkg::SRC_PIN5;
      r.neg = idx ? dcc_pkg::SRC_PIN4 : dcc_pkg::SRC_PIN6;
      case (mode)
         dcc_pkg::MODE_OFF_ZERO: begin
            r.on = 1'b0; // RL20
         end
         dcc_pkg::MODE_INDEP,
         dcc_pkg::MODE_INDEP_OUT: begin
            r.on = 1'b1; // RL20
         end
         dcc_pkg::MODE_COMMON,
         dcc_pkg::MODE_COMMON_OUT: begin
            r.pos = dcc_pkg::SRC_PIN3; // RL20
         end
         dcc_pkg::MODE_SINGLE: begin
            r.on = idx; // RL20
         end
         dcc_pkg::MODE_MUX_REF: begin
            r.pos = dcc_pkg::SRC_IREF; // RL7
            if (idx) begin
               r.neg = sw ? dcc_pkg::SRC_PIN3
                          : dcc_pkg::SRC_PIN4; // RL6
            end else begin
               r.neg = sw ? dcc_pkg::SRC_PIN5
                          : dcc_pkg::SRC_PIN6; // RL6
            end
         end
         dcc_pkg::MODE_OFF: begin
            r.on = 1'b0; // RL5
         end
         default: begin
            r.on = 1'b0;
         end
      endcase
      return r;
   endfunction

   // modes that put results on pins 1 and 2
   function automatic logic pins_enabled(
      input dcc_pkg::dcc_mode_t mode
   );
      return (mode == dcc_pkg::MODE_INDEP_OUT) ||
             (mode == dcc_pkg::MODE_COMMON_OUT);
   endfunction

   // strobe aimed at one register index
   function automatic logic hit(
      input logic strobe,
      input logic [2:0] addr,
      input logic [2:0] idx
   );
      return strobe && (addr == idx);
   endfunction

   // digital threshold of analog-capable pin i (pins 3..6)
   function automatic logic [3:0] dig_from(
      input int i
   );
      logic [3:0] t;
      t = PIN3_DIG_FROM;
      case (i)
         1: t = PIN4_DIG_FROM;
         2: t = PIN5_DIG_FROM;
         3: t = PIN6_DIG_FROM;
         default: t = PIN3_DIG_FROM;
      endcase
      return t;
   endfunction

   // picks an analog level for a source select
   function automatic logic [SAMPLE_W-1:0] level_of(
      input dcc_pkg::dcc_src_t src,
      input logic [NUM_ANA_P-1:0][SAMPLE_W-1:0] ana,
      input logic [SAMPLE_W-1:0] iref
   );
      logic [SAMPLE_W-1:0] v;
      v = iref;
      case (src)
         dcc_pkg::SRC_PIN3: v = ana[0];
         dcc_pkg::SRC_PIN4: v = ana[1];
         dcc_pkg::SRC_PIN5: v = ana[2];
         dcc_pkg::SRC_PIN6: v = ana[3];
         dcc_pkg::SRC_IREF: v = iref;
         default: v = iref;
      endcase
      return v;
   endfunction

   // ==================================================
   // comparators
   // ==================================================
   // raw levels, polarity bits and polarity-applied results
   logic [1:0] raw;
   logic [1:0] inv;
   logic [1:0] cur;

   // invert bits per comparator, second in bit 1
   assign inv = {st.ctrl.second_invert, st.ctrl.first_invert};

   // one comparator per result bit
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_cmp
         dcc_pkg::dcc_route_t rt;
         logic [SAMPLE_W-1:0] vp;
         logic [SAMPLE_W-1:0] vn;
         // mode field picks the routing of this comparator
         assign rt = route_of(st.ctrl.routing_mode, // RL4
                              st.ctrl.input_switch, gi == 1);
         assign vp = level_of(rt.pos, ana_in, internal_reference);
         assign vn = level_of(rt.neg, ana_in, internal_reference);
         // off comparators give a low raw level
         assign raw[gi] = rt.on && (vp > vn); // RL1
      end
   endgenerate

   // polarity applied to both status and pins
   assign cur = raw ^ inv; // RL3

   // ==================================================
   // register port decode
   // ==================================================
   logic wr_ctrl;
   logic rd_ctrl;
   logic wr_flags;
   logic wr_en2;
   logic wr_intctl;
   logic ctrl_access;
   logic mismatch;
   logic [NUM_ANA_P-1:0] analog_cfg;
   logic [dcc_pkg::NUM_PINS-1:0] port_rd;

   // write strobes for indices 0..3, read strobe for control only
   assign wr_ctrl = hit(reg_wr, reg_addr, dcc_pkg::ADDR_CTRL);
   assign rd_ctrl = hit(reg_rd, reg_addr, dcc_pkg::ADDR_CTRL);
   assign wr_flags = hit(reg_wr, reg_addr, dcc_pkg::ADDR_FLAGS2);
   assign wr_en2 = hit(reg_wr, reg_addr, dcc_pkg::ADDR_ENABLES2);
   assign wr_intctl = hit(reg_wr, reg_addr, dcc_pkg::ADDR_INTCTL);

   // any read or write of the control register
   assign ctrl_access = wr_ctrl || rd_ctrl; // RL13

   // compare registered results with the last latched pair
   assign mismatch = (st.result != st.latched); // RL10

   // ==================================================
   // analog pin configuration
   // ==================================================
   // analog when config is below each pin's digital threshold
   genvar ai;
   generate
      for (ai = 0; ai < NUM_ANA_P; ai++) begin : g_ana
         assign analog_cfg[ai] =
            port_analog_config < dig_from(ai); // RL19
      end
   endgenerate

   // analog pins read as zero
   assign port_rd = pin_digital &
                    ~{st.analog, 2'b00}; // RL18

   // ==================================================
   // next state
   // ==================================================
   always_comb begin
      next_st = st;
      next_st.result = cur;

      // control write leaves result bits untouched
      if (wr_ctrl) begin
         next_st.ctrl = dcc_pkg::dcc_ctrl_t'(
            reg_wdata[dcc_pkg::BIT_SECOND_INV:dcc_pkg::MODE_LSB]); // RL2
      end

      // any control access re-arms the mismatch latch; a mismatch
      // pending in that very cycle sets no flag and is lost
      if (ctrl_access) begin
         next_st.latched = st.result; // RL13 RL15
      end

      // software write of the flag, then hardware set wins
      // a clear during a live mismatch is lost
      if (wr_flags) begin
         next_st.flag = reg_wdata[dcc_pkg::BIT_CHANGE_FLAG]; // RL11
      end
      if (mismatch && !ctrl_access) begin
         next_st.flag = 1'b1; // RL10 RL14
      end

      // enable bits
      if (wr_en2) begin
         next_st.change_en = reg_wdata[dcc_pkg::BIT_CHANGE_EN];
      end
      if (wr_intctl) begin
         next_st.periph_en = reg_wdata[dcc_pkg::BIT_PERIPH_EN];
         next_st.global_en = reg_wdata[dcc_pkg::BIT_GLOBAL_EN];
      end

      // request only with all three enables
      next_st.irq = next_st.flag && next_st.change_en &&
                    next_st.periph_en &&
                    next_st.global_en; // RL12
      // wake in sleep on an enabled change
      next_st.wake = sleep_mode && next_st.flag &&
                     next_st.change_en; // RL16

      // pin multiplexers and driver enables
      // pins lag the comparators by one clock
      // so that every top output stays a flop
      if (pins_enabled(st.ctrl.routing_mode)) begin
         next_st.pout = cur; // RL8
      end else begin
         next_st.pout = port_f_latch;
      end
      next_st.poe_n = port_f_direction; // RL9
      next_st.analog = analog_cfg; // RL19

      // read data, one cycle after the strobe
      next_st.rdata = dcc_pkg::ZERO_BYTE;
      if (reg_rd) begin
         case (reg_addr)
            dcc_pkg::ADDR_CTRL: begin
               next_st.rdata = {st.result, st.ctrl}; // RL2
            end
            dcc_pkg::ADDR_FLAGS2: begin
               next_st.rdata[dcc_pkg::BIT_CHANGE_FLAG] = st.flag;
            end
            dcc_pkg::ADDR_ENABLES2: begin
               next_st.rdata[dcc_pkg::BIT_CHANGE_EN] =
                  st.change_en;
            end
            dcc_pkg::ADDR_INTCTL: begin
               next_st.rdata[dcc_pkg::BIT_PERIPH_EN] =
                  st.periph_en;
               next_st.rdata[dcc_pkg::BIT_GLOBAL_EN] =
                  st.global_en;
            end
            dcc_pkg::ADDR_PORTRD: begin
               next_st.rdata = {2'b00, port_rd}; // RL18
            end
            default: begin
               next_st.rdata = dcc_pkg::ZERO_BYTE;
            end
         endcase
      end
   end

   // ==================================================
   // registers
   // ==================================================
   // reset state: mode off, everything else clear
   // except drivers off and pins 3..6 analog
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st <= '0;
         st.ctrl.routing_mode <= dcc_pkg::MODE_OFF; // RL5
         st.poe_n <= 2'b11;
         st.analog <= '1; // RL19
      end else begin
         st <= next_st;
      end
   end

   // ==================================================
   // outputs
   // ==================================================
   // outputs straight from the state flops
   assign reg_rdata = st.rdata;
   assign pin_out = st.pout;
   assign pin_oe_n = st.poe_n;
   assign pin_analog = st.analog;
   assign irq_request = st.irq;
   assign wake_request = st.wake;

endmodule // dcc_top
